// ===== hdl/baud_gen_pkg.sv
// Register map, field layout, reset values and carrier types of the baud generator
package baud_gen_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [35:0] BASE_CLOCK_SELECT_IDX = 36'hFFFFFFA01;
  localparam logic [35:0] BAUD_DIVISOR_IDX      = 36'h0FFFFFA02;
  localparam logic [35:0] CHANNEL_CONTROL_IDX   = 36'h0FFFFFA00;
  localparam logic [35:0] CHANNEL_STATUS_IDX    = 36'h0FFFFFA03;
  localparam int          ADDR_W                = 12;
  // Byte address is four times the index, decoded on the low address bits
  localparam logic [ADDR_W-1:0] BASE_CLOCK_SELECT_ADDR = {BASE_CLOCK_SELECT_IDX[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] BAUD_DIVISOR_ADDR      = {BAUD_DIVISOR_IDX[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] CHANNEL_CONTROL_ADDR   = {CHANNEL_CONTROL_IDX[9:0], 2'b00};
  localparam logic [ADDR_W-1:0] CHANNEL_STATUS_ADDR    = {CHANNEL_STATUS_IDX[9:0], 2'b00};

  // ==========================================================================
  // Reset values and fields
  // ==========================================================================
  localparam logic [7:0] BASE_CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RST      = 8'hFF;
  localparam logic [2:0] CHANNEL_CONTROL_RST   = 3'h0;
  localparam int         CTL_POWER_BIT         = 0;
  localparam int         CTL_TX_ENABLE_BIT     = 1;
  localparam int         CTL_RX_ENABLE_BIT     = 2;
  localparam int         SEL_W                 = 4;
  localparam logic [3:0] SEL_MAX_INTERNAL      = 4'hA;
  localparam logic [3:0] SEL_EXTERNAL          = 4'hB;
  localparam logic [7:0] DIVISOR_MIN           = 8'h04;
  localparam int         PRESCALE_W            = 10;
  localparam logic [1:0] STOP_STRETCH_TICKS    = 2'h2;

  // ==========================================================================
  // Timing carrier towards the shift logic
  // ==========================================================================
  typedef struct packed {
    logic base_tick;    // One pulse per base clock, low while powered down
    logic tx_sclk;      // Transmit serial clock, half period k base clocks
    logic tx_bit_end;   // Pulse at each transmit bit boundary
    logic rx_sclk;      // Receive serial clock
    logic rx_latch;     // Pulse at the centre of each received bit
    logic rx_filtered;  // Noise-filtered receive line
  } baud_timing_s;

endpackage

// ===== hdl/baud_gen.sv
// Baud rate generator for one serial channel with an APB register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// What this block does
// - separate 8-bit transmit and receive counters
// - powered channel routes selected source as base clock
// - unpowered channel holds base clock low
// - select codes 0-10 divide by 2^m, 11 external on channel 0 only
// - divisor k 4..255 divides base clock
// - bit rate is base clock over 2k
// - internal rate is main clock over 2^(m+1)k
// - select register resets 00, 4-bit read/write
// - divisor register resets FF, 8-bit read/write
// - receive counter from divisor times each latch
// - latch at bit centre, two clock margin
// - back-to-back stop bit stretched two base clocks
// - receive filter on base clock, three clock delay
module baud_gen
  import baud_gen_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                external_baud_clock_pin,
  input  wire logic                receive_data_pin,
  input  wire logic                tx_start,
  input  wire logic                tx_back_to_back,
  input  wire logic                rx_start,
  output baud_timing_s             timing,
  output logic                     channel_power_enable,
  output logic                     transmit_enable_bit,
  output logic                     receive_enable_bit
);

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [SEL_W-1:0] base_clock_select_q;
  logic [7:0]       baud_divisor_q;
  logic [2:0]       control_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             setup;
  logic             wr_access;
  logic             addr_hit;
  logic [31:0]      rd_value;
  logic             setting_bad;
  logic [1:0]       sclk_level;

  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pstrb[0];
  assign pready    = 1'b1;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;

  always_comb begin
    addr_hit = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (paddr)
      BASE_CLOCK_SELECT_ADDR: rd_value = {28'h000_0000, base_clock_select_q};
      BAUD_DIVISOR_ADDR:      rd_value = {24'h00_0000, baud_divisor_q};
      CHANNEL_CONTROL_ADDR:   rd_value = {29'h0, control_q};
      CHANNEL_STATUS_ADDR:    rd_value = {28'h000_0000, setting_bad, sclk_level,
                                          timing.rx_filtered};
      default:                addr_hit = 1'b0;
    endcase
  end

  // Read data and error are prepared in the setup cycle so they leave flip-flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr_q <= ~addr_hit;
    end
  end

  // Only the low byte lane is implemented; upper lanes are ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_clock_select_q <= BASE_CLOCK_SELECT_RST[SEL_W-1:0];
      baud_divisor_q      <= BAUD_DIVISOR_RST;
      control_q           <= CHANNEL_CONTROL_RST;
    end else if (wr_access) begin
      if (paddr == BASE_CLOCK_SELECT_ADDR) begin
        base_clock_select_q <= pwdata[SEL_W-1:0];
      end
      if (paddr == BAUD_DIVISOR_ADDR) begin
        baud_divisor_q <= pwdata[7:0];
      end
      if (paddr == CHANNEL_CONTROL_ADDR) begin
        control_q <= pwdata[2:0];
      end
    end
  end

  assign channel_power_enable = control_q[CTL_POWER_BIT];
  assign transmit_enable_bit  = control_q[CTL_TX_ENABLE_BIT];
  assign receive_enable_bit   = control_q[CTL_RX_ENABLE_BIT];

  // ==========================================================================
  // Base clock source selection
  // ==========================================================================
  logic [PRESCALE_W-1:0] prescale_q;
  logic [PRESCALE_W-1:0] prescale_mask;
  logic [2:0]            ext_sync_q;
  logic                  internal_tick;
  logic                  external_tick;
  logic                  base_tick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_q <= '0;
    end else if (!channel_power_enable) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  // Pin passes two flip-flops; the third stage only serves edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_baud_clock_pin};
    end
  end

  always_comb begin
    prescale_mask = '0;
    for (int b = 0; b < PRESCALE_W; b++) begin
      prescale_mask[b] = (b < int'(base_clock_select_q));
    end
  end

  // A tick every 2^m main clocks; m = 0 ticks on every edge
  assign internal_tick = (prescale_q & prescale_mask) == prescale_mask;
  assign external_tick = ext_sync_q[1] & ~ext_sync_q[2];

  // Prohibited codes, and the external pin off channel 0, yield no base clock
  assign setting_bad = (base_clock_select_q > SEL_EXTERNAL) ||
                       ((base_clock_select_q == SEL_EXTERNAL) && (CHANNEL != 0));

  always_comb begin
    if (!channel_power_enable || setting_bad) begin
      base_tick = 1'b0;
    end else if (base_clock_select_q <= SEL_MAX_INTERNAL) begin
      base_tick = internal_tick;
    end else begin
      base_tick = external_tick;
    end
  end

  // ==========================================================================
  // Receive noise filter
  // ==========================================================================
  logic [1:0] rx_sync_q;
  logic [1:0] rx_sample_q;
  logic       rx_filtered_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_sync_q <= 2'h3;
    end else begin
      rx_sync_q <= {rx_sync_q[0], receive_data_pin};
    end
  end

  // Three equal samples move the output, so a pulse of two clocks is dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_sample_q   <= 2'h3;
      rx_filtered_q <= 1'b1;
    end else if (base_tick) begin
      rx_sample_q <= {rx_sample_q[0], rx_sync_q[1]};
      if ((rx_sample_q[0] == rx_sample_q[1]) && (rx_sync_q[1] == rx_sample_q[0])) begin
        rx_filtered_q <= rx_sample_q[1];
      end
    end
  end

  // ==========================================================================
  // Transmit and receive divider counters
  // ==========================================================================
  logic [7:0] divisor_k;
  logic [1:0] run;
  logic [1:0] restart;
  logic [1:0] stretch_req;
  logic [1:0] flip;

  // Prohibited divisors 0..3 behave as 4 so the counters never stall
  assign divisor_k   = (baud_divisor_q < DIVISOR_MIN) ? DIVISOR_MIN : baud_divisor_q;
  assign run         = {receive_enable_bit, transmit_enable_bit};
  assign restart     = {rx_start, tx_start};
  assign stretch_req = {1'b0, tx_back_to_back};

  for (genvar i = 0; i < 2; i++) begin : g_counter
    logic [7:0] cnt_q;
    logic       phase_q;
    logic [1:0] extra_q;
    logic       stretched_q;
    logic       at_end;
    logic       want_stretch;

    assign at_end       = base_tick && (cnt_q == divisor_k - 8'h01) && (extra_q == 2'h0);
    assign want_stretch = phase_q && stretch_req[i] && !stretched_q;
    // A restart in the same cycle wins, so no pulse without a phase change
    assign flip[i]      = at_end && !want_stretch && run[i] && !restart[i];
    assign sclk_level[i] = phase_q;

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_q       <= 8'h00;
        phase_q     <= 1'b0;
        extra_q     <= 2'h0;
        stretched_q <= 1'b0;
      end else if (!run[i] || restart[i]) begin
        cnt_q       <= 8'h00;
        phase_q     <= 1'b0;
        extra_q     <= 2'h0;
        stretched_q <= 1'b0;
      end else if (base_tick) begin
        if (extra_q != 2'h0) begin
          extra_q <= extra_q - 2'h1;
        end else if (at_end && want_stretch) begin
          // The stretch tick itself is the first of the extra ticks
          extra_q     <= STOP_STRETCH_TICKS - 2'h1;
          stretched_q <= 1'b1;
        end else if (at_end) begin
          cnt_q       <= 8'h00;
          phase_q     <= ~phase_q;
          stretched_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Timing outputs
  // ==========================================================================
  baud_timing_s timing_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timing_q <= '0;
    end else begin
      timing_q.base_tick   <= base_tick;
      timing_q.tx_sclk     <= sclk_level[0];
      timing_q.tx_bit_end  <= flip[0] & sclk_level[0];
      timing_q.rx_sclk     <= sclk_level[1];
      // First latch k base clocks after start detect, the centre of the bit
      timing_q.rx_latch    <= flip[1] & ~sclk_level[1];
      timing_q.rx_filtered <= rx_filtered_q;
    end
  end

  assign timing = timing_q;

endmodule

// ===== sim/baud_gen_asserts.sv
// Port-level checks of the baud generator
`timescale 1ns/1ps
module baud_gen_asserts
  import baud_gen_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire baud_timing_s      timing,
  input wire logic              channel_power_enable
);
  logic stp;
  logic rd;
  logic off;
  logic hit;
  assign stp = psel && !penable;
  assign rd  = stp && !pwrite;
  assign off = !channel_power_enable;
  assign hit = paddr inside {CHANNEL_CONTROL_ADDR, BASE_CLOCK_SELECT_ADDR,
                             BAUD_DIVISOR_ADDR, CHANNEL_STATUS_ADDR};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // Timing
  // Output stage lags by a clock or two, hence the repetitions
  property p_tick_off; off [*3] |-> !timing.base_tick; endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick off");
  property p_pulse_off; off [*4] |-> !(timing.tx_bit_end || timing.rx_latch); endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse off");
  property p_tx_gap; timing.tx_bit_end |=> !timing.tx_bit_end [*7]; endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx bit short");
  property p_rx_gap; timing.rx_latch |=> !timing.rx_latch [*3]; endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("rx latch soon");
  property p_tx_sclk; timing.tx_bit_end |=> !timing.tx_sclk; endproperty
  a_tx_sclk: assert property (p_tx_sclk) else $error("tx sclk high");
  property p_rx_sclk; timing.rx_latch |=> timing.rx_sclk; endproperty
  a_rx_sclk: assert property (p_rx_sclk) else $error("rx sclk low");
  property p_filt_hold; off [*4] |=> $stable(timing.rx_filtered); endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter moved");
  // ==========
  // Register port
  property p_bad_addr; stp && !hit |=> pslverr; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no error");
  property p_sel_rd; rd && paddr == BASE_CLOCK_SELECT_ADDR |=> prdata[31:4] == 28'h0; endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select high bits");
  property p_div_rd; rd && paddr == BAUD_DIVISOR_ADDR |=> prdata[31:8] == 24'h0; endproperty
  a_div_rd: assert property (p_div_rd) else $error("divisor high bits");
  property p_rd_hold; !stp |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

// ===== sim/uart_shift_model.sv
// Behavioural shift-logic partner of the baud generator
`timescale 1ns/1ps
module uart_shift_model
  import baud_gen_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire baud_timing_s timing,
  input  wire logic [1:0]   rx_req,
  input  wire logic         tx_req,
  input  wire logic         b2b_req,
  output logic              receive_data_pin,
  output logic              rx_start,
  output logic              tx_start,
  output logic              tx_back_to_back
);
  logic       low_q;
  logic [1:0] left_q;
  logic       filt_q;
  assign receive_data_pin = !low_q;
  // ==========
  // Line: start bit until detected, or a two-clock noise pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_q  <= 1'b0;
      left_q <= 2'h0;
    end else if (rx_req != 2'h0) begin
      low_q  <= 1'b1;
      left_q <= (rx_req == 2'h2) ? 2'h2 : 2'h0;
    end else if (rx_start || left_q == 2'h1) begin
      low_q  <= 1'b0;
      left_q <= 2'h0;
    end else if (left_q != 2'h0) begin
      left_q <= left_q - 2'h1;
    end
  end
  // ==========
  // Start detection and queued-frame flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_q          <= 1'b0;
      rx_start        <= 1'b0;
      tx_start        <= 1'b0;
      tx_back_to_back <= 1'b0;
    end else begin
      filt_q          <= timing.rx_filtered;
      rx_start        <= filt_q && !timing.rx_filtered;
      tx_start        <= tx_req;
      tx_back_to_back <= b2b_req || (tx_back_to_back && !timing.tx_bit_end);
    end
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the baud generator
`timescale 1ns/1ps
module tb_top
  import baud_gen_pkg::*;
;
  logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic              rx_pin, rx_start, tx_start, b2b, pwr_en, txe, rxe, tx_req, b2b_req;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [2:0]        ext_div = 3'h0;
  logic [1:0]        rx_req;
  baud_timing_s      timing;
  int                n_errors, samples_checked, per, cnt, tk, kk;
  // Select code in the high byte, divisor in the low byte
  logic [15:0]       rows [7] = '{16'h0004, 16'h0105, 16'h0341, 16'h0A04, 16'h0B04,
                                  16'h0002, 16'h00FF};
  baud_gen #(.CHANNEL(0)) i_baud_gen (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_baud_clock_pin(ext_div[2]),
    .receive_data_pin(rx_pin), .tx_start(tx_start), .tx_back_to_back(b2b),
    .rx_start(rx_start), .timing(timing), .channel_power_enable(pwr_en),
    .transmit_enable_bit(txe), .receive_enable_bit(rxe));
  uart_shift_model i_uart_shift_model (.clk_sys(clk_sys), .rst(rst), .timing(timing),
    .rx_req(rx_req), .tx_req(tx_req), .b2b_req(b2b_req), .receive_data_pin(rx_pin),
    .rx_start(rx_start), .tx_start(tx_start), .tx_back_to_back(b2b));
  // Bus master runs on the main clock, never slower than the base clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // External base clock: one rising edge every 8 system clocks
  always @(posedge clk_sys) ext_div <= ext_div + 3'h1;
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      n_errors++;
      give_verdict();
    end
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? timing.base_tick : ((w == 1) ? timing.tx_bit_end : timing.rx_latch);
  endfunction
  // Clocks between two pulses; bb queues a frame at the first one
  task automatic measure(input int w, input logic bb);
    per = 0;
    do begin
      @(posedge clk_sys);
      per++;
    end while (pick(w) !== 1'b1 && per < 20000);
    if (per >= 20000) begin
      n_errors++;
      give_verdict();
    end
    b2b_req <= bb;
    per = 0;
    do begin
      @(posedge clk_sys);
      b2b_req <= 1'b0;
      per++;
    end while (pick(w) !== 1'b1 && per < 20000);
    if (per >= 20000) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic kick(input logic [1:0] r);
    @(posedge clk_sys);
    rx_req <= r;
    tx_req <= 1'b1;
    @(posedge clk_sys);
    rx_req <= 2'h0;
    tx_req <= 1'b0;
  endtask
  // Power down before touching select or divisor
  task automatic cfg(input logic [7:0] s, input logic [7:0] k);
    apb(1'b1, CHANNEL_CONTROL_ADDR, 32'h0);
    apb(1'b1, BASE_CLOCK_SELECT_ADDR, {24'h0, s});
    apb(1'b1, BAUD_DIVISOR_ADDR, {24'h0, k});
    apb(1'b1, CHANNEL_CONTROL_ADDR, 32'h7);
  endtask
  task automatic count_ticks();
    cnt = 0;
    repeat (67) begin
      @(posedge clk_sys);
      if (timing.base_tick !== 1'b0 && cnt >= 0) cnt++;
    end
  endtask
  // ==========
  // Sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_req = 2'h0;
    tx_req = 1'b0;
    b2b_req = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      cfg(rows[i][15:8], rows[i][7:0]);
      tk = (rows[i][11:8] == SEL_EXTERNAL) ? 8 : (1 << rows[i][11:8]);
      kk = (rows[i][7:0] < DIVISOR_MIN) ? 4 : rows[i][7:0];
      measure(0, 1'b0);
      chk(per, tk);
      kick(2'h1);
      measure(1, 1'b0);
      chk(per, 2 * kk * tk);
      measure(2, 1'b0);
      chk(per, 2 * kk * tk);
    end
    cfg(8'h00, 8'h04);
    measure(1, 1'b1);
    chk(per, 10);
    measure(1, 1'b0);
    chk(per, 8);
    kick(2'h2);
    repeat (16) begin
      @(posedge clk_sys);
      chk(timing.rx_filtered, 1'b1);
    end
    cfg(8'h0C, 8'h04);
    repeat (3) @(posedge clk_sys);
    count_ticks();
    chk(cnt, 0);
    apb(1'b0, CHANNEL_STATUS_ADDR, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b1, CHANNEL_CONTROL_ADDR, 32'h0);
    apb(1'b1, BASE_CLOCK_SELECT_ADDR, 32'h0);
    repeat (3) @(posedge clk_sys);
    count_ticks();
    chk(cnt, 0);
    apb(1'b1, BASE_CLOCK_SELECT_ADDR, 32'hFA);
    apb(1'b0, BASE_CLOCK_SELECT_ADDR, 32'h0);
    chk(rd, 32'h0A);
    apb(1'b1, BAUD_DIVISOR_ADDR, 32'h41);
    apb(1'b0, BAUD_DIVISOR_ADDR, 32'h0);
    chk(rd, 32'h41);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, BASE_CLOCK_SELECT_ADDR, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, BAUD_DIVISOR_ADDR, 32'h0);
    chk(rd, 32'hFF);
    chk({pwr_en, txe, rxe}, 32'h0);
    give_verdict();
  end
endmodule
bind baud_gen baud_gen_asserts i_baud_gen_asserts (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .timing(timing), .channel_power_enable(channel_power_enable));
